// >>> rtl/spc_pkg.sv
// Types shared by the serial port control field block
package spc_pkg;
  // Maintenance register access from the packet layer
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        crc_bad;
    logic [31:0] wdata;
  } spc_maint_type;
  // Error-rate and output status seen by the port
  typedef struct packed {
    logic rate_failed;
    logic output_failed;
  } spc_err_type;
endpackage : spc_pkg

// >>> rtl/spc_port_ctrl.sv
// Upper control fields of a serial switch port control register and their effects
// Notes on behaviour
// - Bit 11 set disables CRC checking, recovery and all retransmission.
// - Corrupted maintenance write never alters registers, even with checking disabled.
// - With checking enabled, corrupted maintenance packets are rejected.
// - Bit 12 set forwards incoming multicast-event symbols out this port.
// - Bit 14 is a plain marker; resets 1 on port 2, else 0.
// - Bit 28 stop-on-failure enable, resets 0, works with drop enable.
// - Bit 29 drop enable, resets 0, discards rejected packets past threshold.
// - Stop 0, drop 1: drop rejected packets at threshold, flag dropped, else forward.
// - Stop 1, drop 0: halt transmit when output failed; both 0 keeps trying.
// - Both set and output failed: discard queued packets, flag dropped, later ones forward.
// - Lockout clear: port enables, CRC refusal and failure policy govern receive and issue.
// - Lockout set: no packets issued or accepted; link-requests still work.
// - Lockout set: every received packet answered with packet-not-accepted.
// - Packet received under lockout sets inbound error and error-stopped flags.
// - Setting lockout drops fabric packets and flushes transmit and receive queues.
// - Lockout and flushing leave acknowledge identifiers unchanged.
// - Bit 31 always reads 1, a serial port.
`timescale 1ns/10ps
`include "spc_regs.svh"
module spc_port_ctrl #(
  parameter logic [3:0] PORT_NUM = 4'h0
) (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Maintenance access to the control register
  input  wire spc_pkg::spc_maint_type maint,
  output logic [31:0]             ctrl_rdata,
  output logic                    maint_accept,
  output logic                    maint_reject,
  // Lower enable bits held elsewhere
  input  wire logic               input_en,
  input  wire logic               output_en,
  // Error-rate state
  input  wire spc_pkg::spc_err_type err,
  // Inbound packet from the link partner
  input  wire logic               rx_pkt,
  input  wire logic               rx_crc_bad,
  output logic                    rx_accept,
  output logic                    rx_pna,
  output logic                    rx_retry_req,
  // Transmit side towards the partner
  input  wire logic               tx_pkt_ready,
  input  wire logic               tx_pna_seen,
  input  wire logic               tx_queued,
  input  wire logic               fab_pkt,
  output logic                    tx_send,
  output logic                    tx_drop,
  output logic                    fab_drop,
  output logic                    queue_flush,
  // Control symbols and link maintenance
  input  wire logic               mcs_in,
  output logic                    mcs_out,
  output logic                    link_req_allowed,
  // Status flags
  input  wire logic               status_clear,
  output logic                    in_err_reg,
  output logic                    in_err_stop_reg,
  output logic                    out_drop_reg,
  output logic                    crc_check_en
);
  import spc_pkg::*;

  logic [31:0] fields_reg;
  logic        lockout_d_reg;
  logic        queued_dropping_reg;
  logic        fail_d_reg;

  // Named field views
  wire crc_check_disable        = fields_reg[`SPC_CRC_DIS_BIT];
  wire multicast_symbol_forward = fields_reg[`SPC_MCS_FWD_BIT];
  wire stop_fail_en             = fields_reg[`SPC_STOP_FAIL_BIT];
  wire drop_en                  = fields_reg[`SPC_DROP_BIT];
  wire lockout                  = fields_reg[`SPC_LOCKOUT_BIT];
  wire lockout_rise             = lockout & ~lockout_d_reg;
  wire fail_rise                = err.output_failed & ~fail_d_reg;

  // Maintenance acceptance; a corrupted write is never applied
  assign crc_check_en = ~crc_check_disable;
  wire maint_bad   = maint.valid & maint.crc_bad;
  assign maint_reject = maint_bad & crc_check_en;
  assign maint_accept = maint.valid & ~maint_reject;
  wire do_write    = maint_accept & maint.write & ~maint.crc_bad;

  // Reset value depends on port number for the boundary marker
  localparam logic [31:0] ENUM_RST = (PORT_NUM == `SPC_ENUM_PORT) ? (32'h1 << `SPC_ENUM_BIT) : 32'h0;
  wire [31:0] fields_next = (maint.wdata & `SPC_WR_MASK);

  // Control field storage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fields_reg <= 32'h0000_0000;
    end else if (do_write) begin
      fields_reg <= fields_next;
    end
  end

  // Capture reset value of port-dependent bit: merged at read time until written
  logic enum_written_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enum_written_reg <= 1'b0;
    end else if (do_write) begin
      enum_written_reg <= 1'b1;
    end
  end

  // Read view: port type fixed, reserved bits zero, low fields owned elsewhere
  wire [31:0] enum_view = enum_written_reg ? fields_reg : (fields_reg | ENUM_RST);
  assign ctrl_rdata = (enum_view & `SPC_WR_MASK) | (32'h1 << `SPC_PORT_TYPE_BIT);

  // Edge history for lockout and output-failed
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lockout_d_reg <= 1'b0;
      fail_d_reg    <= 1'b0;
    end else begin
      lockout_d_reg <= lockout;
      fail_d_reg    <= err.output_failed;
    end
  end

  // Inbound handling: lockout overrides the enables; link-requests stay alive
  assign link_req_allowed = 1'b1;
  wire rx_crc_err = rx_pkt & rx_crc_bad & crc_check_en;
  assign rx_pna   = rx_pkt & (lockout | ~input_en | rx_crc_err);
  assign rx_accept = rx_pkt & ~rx_pna;
  assign rx_retry_req = rx_crc_err;

  // Both enables set: only packets queued when failure hit are discarded
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      queued_dropping_reg <= 1'b0;
    end else if (fail_rise & stop_fail_en & drop_en & tx_queued) begin
      queued_dropping_reg <= 1'b1;
    end else if (~tx_queued | ~err.output_failed | ~(stop_fail_en & drop_en)) begin
      queued_dropping_reg <= 1'b0;
    end
  end

  // Outbound decisions; lockout silences packet send and drop, multicast symbols still forward
  wire drop_pna  = ~stop_fail_en & drop_en & err.rate_failed & tx_pna_seen;
  wire drop_q    = queued_dropping_reg & tx_pkt_ready;
  wire halt      = stop_fail_en & ~drop_en & err.output_failed;
  assign tx_drop  = ~lockout & (drop_pna | drop_q);
  assign tx_send  = tx_pkt_ready & output_en & ~lockout & ~halt & ~drop_q;
  assign fab_drop = fab_pkt & lockout;
  assign queue_flush = lockout_rise;
  assign mcs_out  = mcs_in & multicast_symbol_forward;

  // Sticky status; a new event wins over a clear in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_err_reg      <= 1'b0;
      in_err_stop_reg <= 1'b0;
      out_drop_reg    <= 1'b0;
    end else begin
      in_err_reg      <= (rx_pkt & lockout) | (in_err_reg & ~status_clear);
      in_err_stop_reg <= (rx_pkt & lockout) | (in_err_stop_reg & ~status_clear);
      out_drop_reg    <= tx_drop | (out_drop_reg & ~status_clear);
    end
  end

  // Checks: lockout on the inbound side
  a_lock_rx_pna: assert property (@(posedge clk) disable iff (!rst_n)
    rx_pkt && lockout |-> rx_pna && !rx_accept)
    else $error("locked packet not refused");

  a_lock_err_flags: assert property (@(posedge clk) disable iff (!rst_n)
    rx_pkt && lockout |=> in_err_reg && in_err_stop_reg)
    else $error("lockout flags not set");

  a_lock_no_accept: assert property (@(posedge clk) disable iff (!rst_n)
    lockout |-> !rx_accept)
    else $error("packet taken during lockout");

  // A clear without a new event must empty the inbound flag
  a_in_err_clear: assert property (@(posedge clk) disable iff (!rst_n)
    status_clear && !(rx_pkt && lockout) |=> !in_err_reg)
    else $error("inbound flag not cleared");

  // Checks: lockout on the outbound side
  a_lock_no_send: assert property (@(posedge clk) disable iff (!rst_n)
    lockout |-> !tx_send && !tx_drop)
    else $error("send during lockout");

  a_flush_once: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(lockout) |-> queue_flush ##1 !queue_flush)
    else $error("flush not single pulse");

  // Flush must come only from the rising edge, never while lockout merely stays set
  a_flush_on_rise: assert property (@(posedge clk) disable iff (!rst_n)
    queue_flush |-> lockout && !$past(lockout))
    else $error("flush without lockout edge");

  a_fab_drop: assert property (@(posedge clk) disable iff (!rst_n)
    fab_pkt && lockout |-> fab_drop)
    else $error("fabric packet kept");

  a_fab_keep: assert property (@(posedge clk) disable iff (!rst_n)
    fab_drop |-> fab_pkt && lockout)
    else $error("fabric packet lost unlocked");

  // Checks: maintenance access and field storage
  a_bad_write_ignored: assert property (@(posedge clk) disable iff (!rst_n)
    maint.valid && maint.write && maint.crc_bad |=> $stable(fields_reg))
    else $error("corrupt write applied");

  a_bad_reject: assert property (@(posedge clk) disable iff (!rst_n)
    maint.valid && maint.crc_bad && !crc_check_disable |-> maint_reject)
    else $error("corrupt packet kept");

  a_answer_excl: assert property (@(posedge clk) disable iff (!rst_n)
    !(maint_accept && maint_reject))
    else $error("accept and reject together");

  // A clean write lands with only the writable bits kept
  a_good_write_lands: assert property (@(posedge clk) disable iff (!rst_n)
    maint.valid && maint.write && !maint.crc_bad |=> fields_reg == ($past(maint.wdata) & `SPC_WR_MASK))
    else $error("clean write not stored");

  a_type_bit_read: assert property (@(posedge clk) disable iff (!rst_n)
    ctrl_rdata[31] && (ctrl_rdata[27:15] == 13'h0) && !ctrl_rdata[13])
    else $error("fixed bits wrong");

  a_enum_reset: assert property (@(posedge clk) disable iff (!rst_n)
    !enum_written_reg |-> ctrl_rdata[`SPC_ENUM_BIT] == (PORT_NUM == `SPC_ENUM_PORT))
    else $error("marker reset value wrong");

  // Checks: CRC checking, retry and the port enables
  a_crc_en_map: assert property (@(posedge clk) disable iff (!rst_n)
    crc_check_en == !fields_reg[`SPC_CRC_DIS_BIT])
    else $error("check enable mismatch");

  a_no_retry_off: assert property (@(posedge clk) disable iff (!rst_n)
    crc_check_disable |-> !rx_retry_req)
    else $error("retry while checking off");

  a_retry_on_bad: assert property (@(posedge clk) disable iff (!rst_n)
    rx_pkt && rx_crc_bad && crc_check_en |-> rx_retry_req && rx_pna)
    else $error("bad packet not refused");

  a_enables_govern: assert property (@(posedge clk) disable iff (!rst_n)
    !lockout && rx_pkt && !rx_crc_bad |-> rx_accept == input_en)
    else $error("input enable ignored");

  a_send_needs_en: assert property (@(posedge clk) disable iff (!rst_n)
    tx_send |-> output_en && tx_pkt_ready)
    else $error("send without enable");

  // Checks: multicast-event symbols
  a_mcs_gate: assert property (@(posedge clk) disable iff (!rst_n)
    mcs_out |-> mcs_in && multicast_symbol_forward)
    else $error("multicast leak");

  a_mcs_pass: assert property (@(posedge clk) disable iff (!rst_n)
    mcs_in && multicast_symbol_forward |-> mcs_out)
    else $error("multicast not forwarded");

  // Checks: failure policy
  a_stop_halt: assert property (@(posedge clk) disable iff (!rst_n)
    stop_fail_en && !drop_en && err.output_failed |-> !tx_send)
    else $error("sent while halted");

  a_both_zero_send: assert property (@(posedge clk) disable iff (!rst_n)
    !stop_fail_en && !drop_en && tx_pkt_ready && output_en && !lockout && !queued_dropping_reg |-> tx_send)
    else $error("send stopped without policy");

  a_pna_drop: assert property (@(posedge clk) disable iff (!rst_n)
    drop_en && !stop_fail_en && err.rate_failed && tx_pna_seen && !lockout |-> tx_drop)
    else $error("refused packet not dropped");

  a_heal_forward: assert property (@(posedge clk) disable iff (!rst_n)
    !err.rate_failed && !queued_dropping_reg |-> !tx_drop)
    else $error("drop after healing");

  a_drop_flag: assert property (@(posedge clk) disable iff (!rst_n)
    tx_drop |=> out_drop_reg)
    else $error("dropped flag missing");

  a_drop_clear: assert property (@(posedge clk) disable iff (!rst_n)
    status_clear && !tx_drop |=> !out_drop_reg)
    else $error("dropped flag not cleared");

  // Both enables: failure hits with packets queued, they drain as drops, then forwarding resumes
  sequence s_fail_hit_queued;
    fail_rise && stop_fail_en && drop_en && tx_queued;
  endsequence
  sequence s_queue_drained;
    queued_dropping_reg && !tx_queued;
  endsequence

  a_queued_arm: assert property (@(posedge clk) disable iff (!rst_n)
    s_fail_hit_queued |=> queued_dropping_reg)
    else $error("queued drop not armed");

  a_queued_drop: assert property (@(posedge clk) disable iff (!rst_n)
    queued_dropping_reg && tx_pkt_ready && !lockout |-> tx_drop && !tx_send)
    else $error("queued packet sent");

  a_queued_release: assert property (@(posedge clk) disable iff (!rst_n)
    s_queue_drained |=> !queued_dropping_reg)
    else $error("queued drop held too long");

endmodule : spc_port_ctrl

// >>> rtl/spc_regs.svh
// Bit positions, reset values and masks of the port control fields
`ifndef SPC_REGS_SVH
`define SPC_REGS_SVH
`define SPC_CRC_DIS_BIT    11
`define SPC_MCS_FWD_BIT    12
`define SPC_ENUM_BIT       14
`define SPC_STOP_FAIL_BIT  28
`define SPC_DROP_BIT       29
`define SPC_LOCKOUT_BIT    30
`define SPC_PORT_TYPE_BIT  31
`define SPC_ENUM_PORT      4'h2
`define SPC_WR_MASK        32'h7000_5800
`endif

// >>> tb/spc_link_partner.sv
// Link partner model that sends inbound packets and notes their rejection
`timescale 1ns/10ps
module spc_link_partner (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Bench request
  input  wire logic send,
  input  wire logic bad,
  // Link side
  output logic      rx_pkt,
  output logic      rx_crc_bad,
  input  wire logic rx_pna,
  output logic      out_err_reg,
  output logic      out_err_stop_reg
);
  // CRC flag reads corrupt outside packets so a stale good value never helps
  assign rx_pkt     = send;
  assign rx_crc_bad = send ? bad : 1'b1;
  // A rejected packet raises both outbound flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_err_reg      <= 1'b0;
      out_err_stop_reg <= 1'b0;
    end else if (rx_pkt && rx_pna) begin
      out_err_reg      <= 1'b1;
      out_err_stop_reg <= 1'b1;
    end
  end
endmodule : spc_link_partner

// >>> tb/test_serial_port_control_fields.sv
// Testbench of the port control fields
`timescale 1ns/10ps
module test_serial_port_control_fields;
  import spc_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, send = 1'b0, bad = 1'b0, acc, rej;
  spc_maint_type maint = '0;
  spc_err_type   err = '0;
  logic tx_rdy = 1'b0, tx_pna = 1'b0, fab = 1'b0, mcs_in = 1'b0;
  logic tx_q = 1'b0, clr = 1'b0, retry;
  logic [31:0] rdata;
  logic m_acc, m_rej, rx_pkt, rx_bad, rx_acc, rx_pna, tx_send, tx_drop, fab_drop, flush;
  logic mcs_out, lreq, in_err, in_stop, out_drop, crc_en, p_err, p_stop;
  int err_total = 0, n_tests = 0;
  // Port 2 so the marker bit resets set
  spc_port_ctrl #(.PORT_NUM(4'h2)) dut_u (.clk(clk), .rst_n(rst_n), .maint(maint),
    .ctrl_rdata(rdata), .maint_accept(m_acc), .maint_reject(m_rej), .input_en(1'b1),
    .output_en(1'b1), .err(err), .rx_pkt(rx_pkt), .rx_crc_bad(rx_bad), .rx_accept(rx_acc),
    .rx_pna(rx_pna), .rx_retry_req(retry), .tx_pkt_ready(tx_rdy), .tx_pna_seen(tx_pna),
    .tx_queued(tx_q), .fab_pkt(fab), .tx_send(tx_send), .tx_drop(tx_drop), .fab_drop(fab_drop),
    .queue_flush(flush), .mcs_in(mcs_in), .mcs_out(mcs_out), .link_req_allowed(lreq),
    .status_clear(clr), .in_err_reg(in_err), .in_err_stop_reg(in_stop),
    .out_drop_reg(out_drop), .crc_check_en(crc_en));
  spc_link_partner partner_u (.clk(clk), .rst_n(rst_n), .send(send), .bad(bad),
    .rx_pkt(rx_pkt), .rx_crc_bad(rx_bad), .rx_pna(rx_pna), .out_err_reg(p_err),
    .out_err_stop_reg(p_stop));
  always #50 clk = ~clk;
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask : chk
  // One maintenance write; answer flags caught mid-cycle
  task automatic wr(logic [31:0] d, logic b);
    @(posedge clk) maint <= '{1'b1, 1'b1, b, d};
    @(negedge clk) acc = m_acc;
    rej = m_rej;
    @(posedge clk) maint <= '0;
    @(negedge clk);
  endtask : wr
  // One inbound packet from the partner
  task automatic pkt(logic b);
    @(posedge clk) send <= 1'b1;
    bad <= b;
    @(negedge clk);
  endtask : pkt
  task automatic t_fields;
    chk("reset view", 32'h8000_4000, rdata);
    wr(32'hbfff_ffff, 1'b0);
    chk("written view", 32'hb000_5800, rdata);
    chk("maint accept", 1, acc);
    chk("check enable", 0, crc_en);
    @(posedge clk) mcs_in <= 1'b1;
    @(negedge clk) chk("mcs out", 1, mcs_out);
    @(posedge clk) mcs_in <= 1'b0;
  endtask : t_fields
  task automatic t_corrupt;
    wr(32'h0, 1'b1);
    chk("corrupt write", 32'hb000_5800, rdata);
    wr(32'h0, 1'b0);
    chk("cleared view", 32'h8000_0000, rdata);
    wr(32'h0000_1000, 1'b1);
    chk("maint reject", 1, rej);
    pkt(1'b1);
    chk("bad pkt accept", 0, rx_acc);
    chk("retry", 1, retry);
    pkt(1'b0);
    chk("good pkt accept", 1, rx_acc);
    @(posedge clk) send <= 1'b0;
  endtask : t_corrupt
  task automatic t_policy;
    wr(32'h2000_0000, 1'b0);
    @(posedge clk) err <= '{1'b1, 1'b0};
    tx_pna <= 1'b1;
    @(negedge clk) chk("drop", 1, tx_drop);
    @(negedge clk) chk("drop flag", 1, out_drop);
    wr(32'h1000_0000, 1'b0);
    @(posedge clk) err <= '{1'b0, 1'b1};
    tx_pna <= 1'b0;
    tx_rdy <= 1'b1;
    @(negedge clk) chk("stopped send", 0, tx_send);
    wr(32'h0, 1'b0);
    chk("free send", 1, tx_send);
  endtask : t_policy
  // Both enables: queued packets drop, later ones go out, then the flag clears
  task automatic t_both;
    @(posedge clk) err <= '0;
    tx_q <= 1'b1;
    wr(32'h3000_0000, 1'b0);
    @(posedge clk) err <= '{1'b0, 1'b1};
    @(negedge clk);
    @(negedge clk) chk("queued drop", 1, tx_drop);
    chk("queued no send", 0, tx_send);
    @(posedge clk) tx_q <= 1'b0;
    @(negedge clk);
    @(negedge clk) chk("later forward", 1, tx_send);
    @(posedge clk) clr <= 1'b1;
    @(negedge clk);
    @(negedge clk) chk("drop flag clear", 0, out_drop);
    @(posedge clk) err <= '0;
    clr <= 1'b0;
    wr(32'h0, 1'b0);
  endtask : t_both
  // Reset in mid-run; clears the partner flags left by the CRC refusal
  task automatic t_rst;
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk) chk("reset again", 32'h8000_4000, rdata);
    chk("partner clear", 2'b00, {p_err, p_stop});
    chk("check on", 1, crc_en);
  endtask : t_rst
  task automatic t_lock;
    wr(32'h4000_0000, 1'b0);
    chk("flush", 1, flush);
    chk("locked send", 0, tx_send);
    chk("link req", 1, lreq);
    @(posedge clk) fab <= 1'b1;
    @(negedge clk) chk("fabric drop", 1, fab_drop);
    pkt(1'b0);
    chk("pna", 1, rx_pna);
    @(posedge clk) send <= 1'b0;
    @(negedge clk) chk("in flags", 2'b11, {in_err, in_stop});
    chk("partner flags", 2'b11, {p_err, p_stop});
  endtask : t_lock
  task automatic wrap_up;
    if (err_total == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    t_fields();
    t_corrupt();
    t_policy();
    t_both();
    t_rst();
    t_lock();
    wrap_up();
  end
  // Watchdog against a hang
  initial begin
    #1000000;
    err_total++;
    wrap_up();
  end
endmodule : test_serial_port_control_fields
